// File: src/rps_crc.sv
// byte-wise crc16 ccitt, lsb first shifting of each byte
`timescale 1ns/1ns
module rps_crc
	import rps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// control
	input wire logic seed,
	input wire logic feed,
	input wire logic [7:0] data,
	// result
	output logic [15:0] crc
);
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ RPS_CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			crc <= RPS_CRC_SEED;
		end else if (seed) begin
			crc <= RPS_CRC_SEED;
		end else if (feed) begin
			crc <= crc_byte(crc, data);
		end
	end
endmodule

// File: src/rps_pkg.sv
// constants and types shared by the remote port front end
package rps_pkg;
	localparam int RPS_CLK_HZ = 20_000_000;
	// high rate keeps a request and its acknowledge short
	localparam int RPS_BAUD = 115_200;
	localparam int RPS_BIT_CYCLES = RPS_CLK_HZ / RPS_BAUD;
	localparam logic [12:0] RPS_BIT_CYC = 13'(RPS_BIT_CYCLES);
	localparam logic [12:0] RPS_HALF_CYC = 13'(RPS_BIT_CYCLES / 2);
	localparam logic [15:0] RPS_CRC_SEED = 16'hffff;
	localparam logic [15:0] RPS_CRC_POLY = 16'h1021;
	localparam logic [2:0] RPS_SPI_CNT_RST = 3'h0;
	localparam logic [1:0] RPS_BYTE_CNT_RST = 2'h0;

	typedef enum logic [2:0] {
		RPS_TX_IDLE = 3'b000,
		RPS_TX_CMD = 3'b001,
		RPS_TX_CRC0 = 3'b010,
		RPS_TX_CRC1 = 3'b011,
		RPS_TX_MSG = 3'b100
	} rps_tx_state_e;
endpackage

// File: src/rps_remote_port.sv
// remote port front end: spi slave or half-duplex uart on shared pins
`timescale 1ns/1ns
// Function
// [R1] The strap low selects the spi slave and high selects the uart.
// [R2] Shared pins serve as select, data in, clock, data out and irq, or as two ios, rx, tx, dir.
// [R3] With the uart selected the select and data-in pins are left to general io.
// [R4] The spi port is a slave only, mode one, sharing the bus with other slaves.
// [R5] The serial output floats whenever no transfer is under way.
// [R6] The host holds the spi clock low while idle.
// [R7] Both sides change their data bit on the rising spi clock edge.
// [R8] Both sides sample incoming data on the falling spi clock edge.
// [R9] Slave select and irq are both active low.
// [R10] The uart is half duplex and never sends while the host sends.
// [R11] Every uart request from the host is answered by an acknowledge.
// [R12] The device may send an unsolicited message on its own.
// [R13] A request starts with a command byte; uart adds a two-byte crc, so does the acknowledge.
// [R14] Uart characters go lsb first and multi-byte values low byte first.
// [R15] The uart crc is ccitt sixteen-bit seeded with all ones.
// [R16] The direction output is high while the uart transmits.
module rps_remote_port
	import rps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// interface select strap
	input wire logic uart_select,
	// shared pins
	input wire logic shared_select_io_a_pin,
	input wire logic shared_din_io_b_pin,
	input wire logic sck_rxd_pin,
	output logic miso_txd_out,
	output logic miso_txd_oe_n,
	output logic shared_irq_direction_pin,
	// spi user side
	input wire logic [7:0] spi_tx_data,
	input wire logic irq_req,
	output logic [7:0] spi_rx_data,
	output logic spi_rx_valid,
	// uart user side
	input wire logic msg_start,
	input wire logic [7:0] msg_data,
	output logic [7:0] uart_cmd,
	output logic uart_cmd_valid,
	output logic uart_busy,
	// general io seen on shared pins in uart mode
	output logic general_io_a,
	output logic general_io_b
);
	logic sel_s, din_s, sck_s, strap_s;
	logic sck_d_reg, uart_reg;
	logic sck_rise, sck_fall, spi_active, uart_mode;

	// select resets to its idle level so miso stays released after reset
	rps_sync #(.RST_VAL(1'b1)) u_sync_sel (.sys_clk(sys_clk), .reset_n(reset_n),
		.din(shared_select_io_a_pin), .dout(sel_s));
	rps_sync u_sync_din (.sys_clk(sys_clk), .reset_n(reset_n),
		.din(shared_din_io_b_pin), .dout(din_s));
	rps_sync u_sync_sck (.sys_clk(sys_clk), .reset_n(reset_n),
		.din(sck_rxd_pin), .dout(sck_s));
	rps_sync u_sync_strap (.sys_clk(sys_clk), .reset_n(reset_n),
		.din(uart_select), .dout(strap_s));

	// strap level decides the mode, caught on the clock
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			uart_reg <= 1'b0;
			sck_d_reg <= 1'b0;
		end else begin
			uart_reg <= strap_s; // [R1]
			sck_d_reg <= sck_s;
		end
	end
	assign uart_mode = uart_reg;
	assign sck_rise = sck_s && !sck_d_reg;
	assign sck_fall = !sck_s && sck_d_reg;
	// select is active low and only counts in spi mode
	assign spi_active = !uart_mode && !sel_s; // [R9] [R2]

	// ---------------- spi slave, mode 1 ----------------
	logic [2:0] spi_cnt_reg;
	logic [7:0] spi_shift_reg, spi_out_reg;
	logic spi_first_reg;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			spi_cnt_reg <= RPS_SPI_CNT_RST;
			spi_shift_reg <= 8'h00;
			spi_out_reg <= 8'h00;
			spi_first_reg <= 1'b1;
			spi_rx_data <= 8'h00;
			spi_rx_valid <= 1'b0;
		end else begin
			spi_rx_valid <= 1'b0;
			if (!spi_active) begin
				spi_cnt_reg <= RPS_SPI_CNT_RST;
				spi_first_reg <= 1'b1;
			end else begin
				// shift out on rising edge, msb first
				if (sck_rise) begin // [R7] [R4]
					if (spi_first_reg) begin
						spi_out_reg <= spi_tx_data;
						spi_first_reg <= 1'b0;
					end else begin
						spi_out_reg <= {spi_out_reg[6:0], 1'b0};
					end
				end
				// sample on falling edge
				if (sck_fall) begin // [R8]
					spi_shift_reg <= {spi_shift_reg[6:0], din_s};
					spi_cnt_reg <= 3'(spi_cnt_reg + 3'h1);
					if (spi_cnt_reg == 3'h7) begin
						spi_rx_data <= {spi_shift_reg[6:0], din_s};
						spi_rx_valid <= 1'b1;
						spi_first_reg <= 1'b1;
					end
				end
			end
		end
	end

	// ---------------- uart receive ----------------
	logic [12:0] rx_tmr_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_busy_reg, rx_done_reg;
	logic [1:0] rx_byte_reg;
	logic tx_busy;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rx_tmr_reg <= 13'h0000;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			rx_busy_reg <= 1'b0;
			rx_done_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			// no reception while transmitting: half duplex
			if (!uart_mode || tx_busy) begin // [R10]
				rx_busy_reg <= 1'b0;
			end else if (!rx_busy_reg) begin
				if (!sck_s) begin
					rx_busy_reg <= 1'b1;
					rx_tmr_reg <= RPS_HALF_CYC;
					rx_bit_reg <= 4'h0;
				end
			end else if (rx_tmr_reg != 13'h0000) begin
				rx_tmr_reg <= 13'(rx_tmr_reg - 13'h0001);
			end else begin
				rx_tmr_reg <= RPS_BIT_CYC - 13'h0001;
				rx_bit_reg <= 4'(rx_bit_reg + 4'h1);
				if (rx_bit_reg == 4'h0) begin
					if (sck_s) begin
						rx_busy_reg <= 1'b0;
					end
				end else if (rx_bit_reg <= 4'h8) begin
					rx_shift_reg <= {sck_s, rx_shift_reg[7:1]}; // [R14]
				end else if (rx_bit_reg == 4'h9) begin
					// stay busy to the end of the stop bit, so an answer
					// never overlaps the host's own stop bit
					rx_done_reg <= sck_s;
					rx_tmr_reg <= RPS_HALF_CYC - 13'h0004; // [R10]
				end else begin
					rx_busy_reg <= 1'b0;
				end
			end
		end
	end

	// request framing: command then crc low, crc high
	logic [15:0] rx_crc, tx_crc;
	logic [7:0] cmd_reg;
	logic ack_pend_reg;

	rps_crc u_rx_crc (.sys_clk(sys_clk), .reset_n(reset_n),
		.seed(!rx_busy_reg && rx_byte_reg == RPS_BYTE_CNT_RST), .feed(rx_done_reg),
		.data(rx_shift_reg), .crc(rx_crc));

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rx_byte_reg <= RPS_BYTE_CNT_RST;
			cmd_reg <= 8'h00;
			ack_pend_reg <= 1'b0;
			uart_cmd <= 8'h00;
			uart_cmd_valid <= 1'b0;
		end else begin
			uart_cmd_valid <= 1'b0;
			if (ack_pend_reg && tx_busy) begin
				ack_pend_reg <= 1'b0;
			end
			if (rx_done_reg) begin
				case (rx_byte_reg)
					2'h0: begin
						cmd_reg <= rx_shift_reg; // [R13]
						rx_byte_reg <= 2'h1;
					end
					2'h1: begin
						rx_byte_reg <= 2'h2;
					end
					default: begin
						rx_byte_reg <= RPS_BYTE_CNT_RST;
						uart_cmd <= cmd_reg;
						uart_cmd_valid <= 1'b1;
						ack_pend_reg <= 1'b1; // [R11]
					end
				endcase
			end
		end
	end

	// ---------------- uart transmit ----------------
	rps_tx_state_e tx_state_reg;
	logic [12:0] tx_tmr_reg;
	logic [3:0] tx_bit_reg;
	logic [9:0] tx_frame_reg;
	logic tx_load, tx_shift_busy_reg, tx_seed;
	logic [7:0] tx_byte;

	assign tx_busy = tx_state_reg != RPS_TX_IDLE;
	assign tx_seed = tx_state_reg == RPS_TX_IDLE;
	assign tx_load = tx_busy && !tx_shift_busy_reg && (tx_bit_reg == 4'h0);

	always_comb begin
		tx_byte = cmd_reg;
		case (tx_state_reg)
			RPS_TX_CRC0: tx_byte = tx_crc[7:0]; // [R14]
			RPS_TX_CRC1: tx_byte = tx_crc[15:8];
			RPS_TX_MSG: tx_byte = msg_data;
			default: tx_byte = cmd_reg;
		endcase
	end

	rps_crc u_tx_crc (.sys_clk(sys_clk), .reset_n(reset_n),
		.seed(tx_seed), .feed(tx_load && (tx_state_reg == RPS_TX_CMD)),
		.data(tx_byte), .crc(tx_crc)); // [R15] [R13]

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tx_state_reg <= RPS_TX_IDLE;
			tx_tmr_reg <= 13'h0000;
			tx_bit_reg <= 4'h0;
			tx_frame_reg <= 10'h3ff;
			tx_shift_busy_reg <= 1'b0;
		end else if (!uart_mode) begin
			tx_state_reg <= RPS_TX_IDLE;
			tx_shift_busy_reg <= 1'b0;
			tx_bit_reg <= 4'h0;
		end else if (tx_state_reg == RPS_TX_IDLE) begin
			// start only when the line is quiet
			if (!rx_busy_reg && rx_byte_reg == RPS_BYTE_CNT_RST) begin // [R10]
				if (ack_pend_reg) begin
					tx_state_reg <= RPS_TX_CMD;
				end else if (msg_start) begin
					tx_state_reg <= RPS_TX_MSG; // [R12]
				end
			end
		end else if (tx_load) begin
			tx_frame_reg <= {1'b1, tx_byte, 1'b0};
			tx_shift_busy_reg <= 1'b1;
			tx_tmr_reg <= RPS_BIT_CYC - 13'h0001;
			tx_bit_reg <= 4'h1;
		end else if (tx_tmr_reg != 13'h0000) begin
			tx_tmr_reg <= 13'(tx_tmr_reg - 13'h0001);
		end else if (tx_bit_reg != 4'ha) begin
			tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
			tx_tmr_reg <= RPS_BIT_CYC - 13'h0001;
			tx_bit_reg <= 4'(tx_bit_reg + 4'h1);
		end else begin
			tx_bit_reg <= 4'h0;
			tx_shift_busy_reg <= 1'b0;
			case (tx_state_reg)
				RPS_TX_CMD: tx_state_reg <= RPS_TX_CRC0;
				RPS_TX_CRC0: tx_state_reg <= RPS_TX_CRC1;
				default: tx_state_reg <= RPS_TX_IDLE;
			endcase
		end
	end

	// ---------------- pin drivers ----------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			miso_txd_out <= 1'b0;
			miso_txd_oe_n <= 1'b1;
			shared_irq_direction_pin <= 1'b1;
			uart_busy <= 1'b0;
			general_io_a <= 1'b0;
			general_io_b <= 1'b0;
		end else if (uart_mode) begin
			miso_txd_out <= tx_shift_busy_reg ? tx_frame_reg[0] : 1'b1;
			miso_txd_oe_n <= !tx_busy; // [R5]
			shared_irq_direction_pin <= tx_busy; // [R16]
			uart_busy <= tx_busy;
			general_io_a <= sel_s; // [R3]
			general_io_b <= din_s;
		end else begin
			miso_txd_out <= spi_out_reg[7];
			miso_txd_oe_n <= !spi_active; // [R5]
			shared_irq_direction_pin <= !irq_req; // [R9]
			uart_busy <= 1'b0;
			general_io_a <= 1'b0;
			general_io_b <= 1'b0;
		end
	end
endmodule

// File: src/rps_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ns
module rps_sync #(
	// level held in reset, the idle level of the pin
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			meta_reg <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

// File: verif/rps_host.sv
// host controller model on the remote port pins
`timescale 1ns/1ns
module rps_host
	import rps_pkg::*;
(
	// host driven pins
	output logic sel_n,
	output logic mosi,
	output logic sck_rxd,
	// device line as seen at the pin
	input wire logic miso_txd
);
	// one uart bit in ns at the 50 ns system clock
	localparam int BIT_NS = RPS_BIT_CYCLES * 50;
	logic [7:0] got;
	initial begin
		sel_n = 1'b1;
		mosi = 1'b0;
		sck_rxd = 1'b0;
	end
	task automatic select(input logic v);
		sel_n = v;
		#420;
	endtask
	task automatic line_idle(input logic v);
		sck_rxd = v;
	endtask
	// mode one byte, 400 ns link clock, msb first
	task automatic spi_byte(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			sck_rxd = 1'b1;
			mosi = tx[i];
			#200 sck_rxd = 1'b0;
			got = {got[6:0], miso_txd};
			#200;
		end
		mosi = ~mosi;
	endtask
	task automatic uart_tx(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			sck_rxd = f[i];
			#BIT_NS;
		end
	endtask
	// returns in the middle of the stop bit
	task automatic uart_rx();
		wait (miso_txd === 1'b1);
		wait (miso_txd === 1'b0);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			#BIT_NS got = {miso_txd, got[7:1]};
		end
		#BIT_NS;
	endtask
endmodule

// File: verif/rps_remote_port_asserts.sv
// checker for the remote port front end
`timescale 1ns/1ns
module rps_remote_port_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// watched ports
	input wire logic uart_select,
	input wire logic shared_select_io_a_pin,
	input wire logic shared_din_io_b_pin,
	input wire logic irq_req,
	input wire logic miso_txd_oe_n,
	input wire logic shared_irq_direction_pin,
	input wire logic spi_rx_valid,
	input wire logic uart_cmd_valid,
	input wire logic uart_busy,
	input wire logic general_io_a,
	input wire logic general_io_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence spi_mode; (reset_n && !uart_select)[*6]; endsequence
	sequence uart_mode; (reset_n && uart_select)[*6]; endsequence
	chk_spi_float: assert property (spi_mode ##0 shared_select_io_a_pin[*6] |-> miso_txd_oe_n)
		else $error("miso driven while deselected");
	chk_irq_low: assert property (spi_mode ##0 irq_req[*3] |-> !shared_irq_direction_pin)
		else $error("irq not low");
	chk_irq_high: assert property (spi_mode ##0 !irq_req[*3] |-> shared_irq_direction_pin)
		else $error("irq not high");
	chk_dir_tx: assert property (uart_mode ##0 uart_busy[*2] |-> shared_irq_direction_pin)
		else $error("dir low while sending");
	chk_dir_idle: assert property (uart_mode ##0 !uart_busy[*4] |->
		!$past(shared_irq_direction_pin) && $past(miso_txd_oe_n))
		else $error("dir or drive while idle");
	chk_gpio_a: assert property (uart_mode ##0 shared_select_io_a_pin[*4] |-> general_io_a)
		else $error("io a lost");
	chk_gpio_b: assert property (uart_mode ##0 !shared_din_io_b_pin[*4] |-> !general_io_b)
		else $error("io b lost");
	chk_ack_start: assert property (uart_cmd_valid |-> ##[1:100] uart_busy)
		else $error("no acknowledge");
	chk_cmd_pulse: assert property (uart_cmd_valid |=> !uart_cmd_valid)
		else $error("command pulse too long");
	chk_uart_quiet: assert property (uart_mode |-> !spi_rx_valid)
		else $error("spi active in uart mode");
endmodule
bind rps_remote_port rps_remote_port_asserts rps_remote_port_asserts_i (.sys_clk, .reset_n,
	.uart_select, .shared_select_io_a_pin, .shared_din_io_b_pin, .irq_req, .miso_txd_oe_n,
	.shared_irq_direction_pin, .spi_rx_valid, .uart_cmd_valid, .uart_busy, .general_io_a,
	.general_io_b);

// File: verif/tb.sv
// self-checking bench for the remote port front end
`timescale 1ns/1ns
module tb
	import rps_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, uart_select = 0, irq_req = 0, msg_start = 0;
	logic gpio_a = 0, gpio_b = 0;
	logic [7:0] spi_tx_data = 0, msg_data = 0, spi_rx_data, uart_cmd, b;
	logic miso_txd_out, miso_txd_oe_n, shared_irq_direction_pin, spi_rx_valid;
	logic uart_cmd_valid, uart_busy, general_io_a, general_io_b, host_sel, mosi, sck_rxd;
	logic [15:0] crc;
	int seed = 30, n_fail = 0, checked = 0;
	logic [7:0] exp_q[$];
	// released line falls to the pull-down
	wire miso_line = miso_txd_oe_n ? 1'b0 : miso_txd_out;
	wire sel_pin = uart_select ? gpio_a : host_sel;
	wire din_pin = uart_select ? gpio_b : mosi;
	always #25 sys_clk = ~sys_clk;
	rps_remote_port rps_remote_port_i (.sys_clk, .reset_n, .uart_select,
		.shared_select_io_a_pin(sel_pin), .shared_din_io_b_pin(din_pin), .sck_rxd_pin(sck_rxd),
		.miso_txd_out, .miso_txd_oe_n, .shared_irq_direction_pin, .spi_tx_data, .irq_req,
		.spi_rx_data, .spi_rx_valid, .msg_start, .msg_data, .uart_cmd, .uart_cmd_valid,
		.uart_busy, .general_io_a, .general_io_b);
	rps_host rps_host_i (.sel_n(host_sel), .mosi, .sck_rxd, .miso_txd(miso_line));
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic compare(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] d);
		logic [15:0] c;
		c = RPS_CRC_SEED;
		for (int i = 0; i < 8; i++) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? RPS_CRC_POLY : 16'h0000);
		end
		return c;
	endfunction
	// oldest note against each result pulse
	always @(negedge sys_clk) begin
		if (spi_rx_valid === 1'b1) compare("spi_rx_data", exp_q.size() ? exp_q.pop_front() : 8'hxx, spi_rx_data);
		if (uart_cmd_valid === 1'b1) compare("uart_cmd", exp_q.size() ? exp_q.pop_front() : 8'hxx, uart_cmd);
	end
	task automatic conclude();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_fail++;
		$display("MISMATCH watchdog expected done seen timeout");
		conclude();
	end
	initial begin
		tick(5);
		reset_n = 1'b1;
		tick(4);
		rps_host_i.select(1'b0);
		for (int i = 0; i < 2; i++) begin
			spi_tx_data = 8'($random(seed));
			b = 8'($random(seed));
			exp_q.push_back(b);
			rps_host_i.spi_byte(b);
			compare("miso byte", spi_tx_data, rps_host_i.got);
		end
		rps_host_i.select(1'b1);
		rps_host_i.spi_byte(8'($random(seed)));
		compare("float line", 8'h00, rps_host_i.got);
		compare("miso release", 8'h01, {7'h0, miso_txd_oe_n});
		tick(1);
		irq_req = 1'b1;
		tick(4);
		compare("irq pin", 8'h00, {7'h0, shared_irq_direction_pin});
		irq_req = 1'b0;
		tick(4);
		compare("irq pin", 8'h01, {7'h0, shared_irq_direction_pin});
		$display("test spi done");
		uart_select = 1'b1;
		rps_host_i.line_idle(1'b1);
		{gpio_a, gpio_b} = 2'($random(seed));
		tick(8);
		compare("general io", {6'h0, gpio_a, gpio_b}, {6'h0, general_io_a, general_io_b});
		compare("dir idle", 8'h00, {7'h0, shared_irq_direction_pin});
		b = 8'($random(seed));
		crc = crc16(b);
		exp_q.push_back(b);
		fork
			begin
				rps_host_i.uart_tx(b);
				rps_host_i.uart_tx(crc[7:0]);
				rps_host_i.uart_tx(crc[15:8]);
			end
			for (int i = 0; i < 3; i++) begin
				rps_host_i.uart_rx();
				compare("ack byte", i == 0 ? b : i == 1 ? crc[7:0] : crc[15:8], rps_host_i.got);
			end
		join
		for (int k = 0; k < 9000 && uart_busy !== 1'b0; k++) tick(1);
		tick(2);
		compare("busy end", 8'h00, {7'h0, uart_busy});
		compare("dir end", 8'h00, {7'h0, shared_irq_direction_pin});
		$display("test request done");
		msg_data = 8'($random(seed));
		msg_start = 1'b1;
		tick(1);
		msg_start = 1'b0;
		rps_host_i.uart_rx();
		compare("message", msg_data, rps_host_i.got);
		tick(8);
		compare("pending", 8'h00, 8'(exp_q.size()));
		$display("test message done");
		conclude();
	end
endmodule
